// *** rfo_ctrl_bank.v ***
// Purpose: APB register bank that clears reference interrupts, steps the
//          incremental phase offset and overrides reference validation.
// Assumes: One clock, synchronous active-high reset, APB3 master.
// Notes:   Byte address is four times the register index.
`timescale 1ns/100ps
`include "rfo_regs.vh"
module rfo_ctrl_bank #(
  parameter ADDR_W = 16,
  parameter OFS_W = 24,
  parameter STEP_W = 16
) (
  input wire clk,
  input wire srst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  input wire [STEP_W-1:0] step_size,
  output reg [3:0] ref_fault_clr,
  output reg [3:0] ref_fault_cleared_clr,
  output reg [3:0] ref_validated_clr,
  output reg [3:0] force_timeout,
  output reg [3:0] mon_override,
  output reg [3:0] mon_bypass,
  output wire [OFS_W-1:0] phase_offset,
  output reg irq
);

  //////////////////////////////////////////////////////////////////////////
  // Bus slave: one wait state, so read data can come from a flip-flop.

  reg ready_q;
  reg err_q;
  reg [31:0] prdata_d;
  reg hit_d;
  wire [`RFO_IDX_W-1:0] idx;
  wire access;
  wire wr_take;
  wire rd_take;
  wire [7:0] wbyte;

  assign idx = paddr[`RFO_IDX_W+1:2];
  assign access = psel && penable;
  assign wr_take = access && ready_q && pwrite && !err_q;
  assign rd_take = access && !ready_q;
  assign wbyte = pwdata[7:0];
  assign pready = ready_q;
  assign pslverr = ready_q && err_q;

  reg [3:0] mon_override_q;
  reg [3:0] mon_bypass_q;
  reg [`RFO_EV_W-1:0] ev_stat_q;
  reg [`RFO_EV_W-1:0] ev_mask_q;
  wire [OFS_W-1:0] offset_w;
  wire wrap_w;

  always @* begin
    prdata_d = 32'h00000000;
    hit_d = 1'b1;
    case (idx)
      // Action registers are write-only and read back as zero.
      `RFO_IDX_CLR_AB: prdata_d = 32'h00000000;
      `RFO_IDX_CLR_CD: prdata_d = 32'h00000000;
      `RFO_IDX_PHASE_CTL: prdata_d = 32'h00000000;
      `RFO_IDX_FORCE_TMO: prdata_d = 32'h00000000;
      `RFO_IDX_MON_OVR: prdata_d = {28'h0000000, mon_override_q};
      `RFO_IDX_MON_BYP: prdata_d = {28'h0000000, mon_bypass_q};
      `RFO_IDX_IRQ_STAT: prdata_d = {28'h0000000, ev_stat_q};
      `RFO_IDX_IRQ_MASK: prdata_d = {28'h0000000, ev_mask_q};
      `RFO_IDX_PHASE_VAL: prdata_d = {{(32-OFS_W){offset_w[OFS_W-1]}}, offset_w};
      default: hit_d = 1'b0;
    endcase
  end

  always @(posedge clk) begin
    if (srst) begin
      ready_q <= 1'b0;
      err_q <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      ready_q <= rd_take;
      if (rd_take) begin
        err_q <= !hit_d;
        prdata <= (pwrite || !hit_d) ? 32'h00000000 : prdata_d;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Action pulses. Each stands exactly one cycle after the write edge.

  wire wr_clr_ab;
  wire wr_clr_cd;
  wire wr_phase;
  wire wr_force;
  reg ph_inc_q;
  reg ph_dec_q;
  reg ph_zero_q;

  assign wr_clr_ab = wr_take && (idx == `RFO_IDX_CLR_AB);
  assign wr_clr_cd = wr_take && (idx == `RFO_IDX_CLR_CD);
  assign wr_phase = wr_take && (idx == `RFO_IDX_PHASE_CTL);
  assign wr_force = wr_take && (idx == `RFO_IDX_FORCE_TMO);

  wire [3:0] fault_clr_d;
  wire [3:0] fault_cleared_clr_d;
  wire [3:0] validated_clr_d;

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_pair
      // Register g carries input 2g in its low nibble and input 2g+1 in the
      // same place of its high nibble, so both registers decode alike.
      wire pair_wr;
      assign pair_wr = (g == 0) ? wr_clr_ab : wr_clr_cd;
      assign fault_clr_d[2*g] = pair_wr &&
        wbyte[`RFO_CLR_FAULT];
      assign fault_clr_d[2*g+1] = pair_wr &&
        wbyte[`RFO_CLR_HI_OFS+`RFO_CLR_FAULT];
      assign fault_cleared_clr_d[2*g] = pair_wr &&
        wbyte[`RFO_CLR_FAULT_CLEARED];
      assign fault_cleared_clr_d[2*g+1] = pair_wr &&
        wbyte[`RFO_CLR_HI_OFS+`RFO_CLR_FAULT_CLEARED];
      assign validated_clr_d[2*g] = pair_wr &&
        wbyte[`RFO_CLR_VALIDATED];
      assign validated_clr_d[2*g+1] = pair_wr &&
        wbyte[`RFO_CLR_HI_OFS+`RFO_CLR_VALIDATED];
    end
  endgenerate

  // One process owns each clear vector, so no bit has two drivers.
  always @(posedge clk) begin
    if (srst) begin
      ref_fault_clr <= 4'h0;
      ref_fault_cleared_clr <= 4'h0;
      ref_validated_clr <= 4'h0;
    end else begin
      ref_fault_clr <= fault_clr_d;
      ref_fault_cleared_clr <= fault_cleared_clr_d;
      ref_validated_clr <= validated_clr_d;
    end
  end

  // Bits 3 and 7 of the clear registers and the upper bits of the other
  // action registers are simply not looked at.
  always @(posedge clk) begin
    if (srst) begin
      force_timeout <= 4'h0;
      ph_inc_q <= 1'b0;
      ph_dec_q <= 1'b0;
      ph_zero_q <= 1'b0;
    end else begin
      force_timeout <= wr_force ? (wbyte[3:0] & `RFO_REF_MASK) : 4'h0;
      ph_inc_q <= wr_phase && wbyte[`RFO_PH_INC];
      ph_dec_q <= wr_phase && wbyte[`RFO_PH_DEC];
      ph_zero_q <= wr_phase && wbyte[`RFO_PH_ZERO];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Static override and bypass levels.

  always @(posedge clk) begin
    if (srst) begin
      mon_override_q <= `RFO_MON_RST;
      mon_bypass_q <= `RFO_MON_RST;
    end else begin
      if (wr_take && (idx == `RFO_IDX_MON_OVR)) begin
        mon_override_q <= wbyte[3:0];
      end
      if (wr_take && (idx == `RFO_IDX_MON_BYP)) begin
        mon_bypass_q <= wbyte[3:0];
      end
    end
  end

  always @* begin
    mon_override = mon_override_q;
    mon_bypass = mon_bypass_q;
  end

  //////////////////////////////////////////////////////////////////////////
  // Phase offset accumulator.

  rfo_phase_accum #(
    .OFS_W(OFS_W),
    .STEP_W(STEP_W)
  ) u_accum (
    .clk(clk),
    .srst(srst),
    .inc_pulse(ph_inc_q),
    .dec_pulse(ph_dec_q),
    .zero_pulse(ph_zero_q),
    .step_size(step_size),
    .offset_q(offset_w),
    .wrap_q(wrap_w)
  );

  assign phase_offset = offset_w;

  //////////////////////////////////////////////////////////////////////////
  // Interrupt status: sticky, write one to clear, a new event beats the
  // clear written in the same cycle so nothing is lost.

  reg step_done_q;
  wire [`RFO_EV_W-1:0] ev_set;
  wire [`RFO_EV_W-1:0] ev_clr;

  assign ev_set = {wr_take_err_pulse(access, ready_q, err_q),
                   |force_timeout, wrap_w, step_done_q};
  assign ev_clr = (wr_take && (idx == `RFO_IDX_IRQ_STAT)) ?
    wbyte[`RFO_EV_W-1:0] : {`RFO_EV_W{1'b0}};

  function wr_take_err_pulse;
    input a;
    input r;
    input e;
    begin
      wr_take_err_pulse = a && r && e;
    end
  endfunction

  always @(posedge clk) begin
    if (srst) begin
      step_done_q <= 1'b0;
      ev_stat_q <= `RFO_EV_RST;
      ev_mask_q <= `RFO_EV_MASK_RST;
      irq <= 1'b0;
    end else begin
      step_done_q <= ph_inc_q || ph_dec_q || ph_zero_q;
      ev_stat_q <= (ev_stat_q & ~ev_clr) | ev_set;
      if (wr_take && (idx == `RFO_IDX_IRQ_MASK)) begin
        ev_mask_q <= wbyte[`RFO_EV_W-1:0];
      end
      irq <= |(((ev_stat_q & ~ev_clr) | ev_set) & ev_mask_q);
    end
  end

endmodule

// *** rfo_ctrl_chk.sv ***
// Purpose: Checks the pulses and levels of the control bank.
// Assumes: step_size is held steady around phase writes.
// Notes: Byte address is four times the register index.
`timescale 1ns/100ps
module rfo_ctrl_chk #(
  parameter ADDR_W = 16,
  parameter OFS_W = 24,
  parameter STEP_W = 16
) (
  input logic clk,
  input logic srst,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic pready,
  input logic [ADDR_W-1:0] paddr,
  input logic [31:0] pwdata,
  input logic [STEP_W-1:0] step_size,
  input logic [3:0] ref_fault_clr,
  input logic [3:0] ref_fault_cleared_clr,
  input logic [3:0] ref_validated_clr,
  input logic [3:0] force_timeout,
  input logic [3:0] mon_override,
  input logic [3:0] mon_bypass,
  input logic [OFS_W-1:0] phase_offset
);
  // A write that completed last cycle, with its index and data.
  logic wr_q;
  logic [13:0] ix_q;
  logic [7:0] pw_q;
  always_ff @(posedge clk) begin
    wr_q <= !srst && psel && penable && pready && pwrite;
    ix_q <= paddr[15:2];
    pw_q <= pwdata[7:0];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_wr(logic [13:0] ix);
    wr_q && ix_q == ix;
  endsequence
  sequence s_ph(logic [2:0] m);
    s_wr(14'h0a0a) ##0 pw_q[2:0] == m;
  endsequence
  clr_ab_a: assert property (s_wr(14'h0a08) |->
    {ref_validated_clr[1:0], ref_fault_cleared_clr[1:0], ref_fault_clr[1:0]} ==
    {pw_q[6], pw_q[2], pw_q[5], pw_q[1], pw_q[4], pw_q[0]}) else $error("clear a b wrong");
  clr_cd_a: assert property (s_wr(14'h0a09) |->
    {ref_validated_clr[3:2], ref_fault_cleared_clr[3:2], ref_fault_clr[3:2]} ==
    {pw_q[6], pw_q[2], pw_q[5], pw_q[1], pw_q[4], pw_q[0]}) else $error("clear c d wrong");
  clr_cause_a: assert property (
    |{ref_fault_clr, ref_fault_cleared_clr, ref_validated_clr} |-> wr_q && ix_q[13:1] == 13'h0504)
    else $error("clear pulse without write");
  pulse_once_a: assert property (
    |{ref_fault_clr, ref_fault_cleared_clr, ref_validated_clr, force_timeout} |=>
    !(|{ref_fault_clr, ref_fault_cleared_clr, ref_validated_clr, force_timeout}))
    else $error("pulse too long");
  force_a: assert property (
    force_timeout == ((wr_q && ix_q == 14'h0a0b) ? pw_q[3:0] : 4'h0)) else $error("force wrong");
  ovr_a: assert property (
    mon_override == ((wr_q && ix_q == 14'h0a0c) ? pw_q[3:0] : $past(mon_override)))
    else $error("override wrong");
  byp_a: assert property (
    mon_bypass == ((wr_q && ix_q == 14'h0a0d) ? pw_q[3:0] : $past(mon_bypass)))
    else $error("bypass wrong");
  ph_zero_a: assert property (s_wr(14'h0a0a) ##0 pw_q[2] |=> phase_offset == '0)
    else $error("offset not zeroed");
  ph_dec_a: assert property (s_ph(3'b010) |=>
    phase_offset == $past(phase_offset) - $past(step_size)) else $error("decrement wrong");
  ph_inc_a: assert property (s_ph(3'b001) |=>
    phase_offset == $past(phase_offset) + $past(step_size)) else $error("increment wrong");
endmodule
bind rfo_ctrl_bank rfo_ctrl_chk #(.ADDR_W(ADDR_W), .OFS_W(OFS_W), .STEP_W(STEP_W)) u_chk (
  .clk, .srst, .psel, .penable, .pwrite, .pready, .paddr, .pwdata, .step_size, .ref_fault_clr,
  .ref_fault_cleared_clr, .ref_validated_clr, .force_timeout, .mon_override, .mon_bypass,
  .phase_offset);

// *** rfo_phase_accum.v ***
// Purpose: Incremental phase offset accumulator stepped by software.
// Assumes: Step size comes from a register on the same clock.
// Notes:   Wraps in two's complement and flags the wrap.
`timescale 1ns/100ps
module rfo_phase_accum #(
  parameter OFS_W = 24,
  parameter STEP_W = 16
) (
  input wire clk,
  input wire srst,
  input wire inc_pulse,
  input wire dec_pulse,
  input wire zero_pulse,
  input wire [STEP_W-1:0] step_size,
  output reg [OFS_W-1:0] offset_q,
  output reg wrap_q
);

  wire [OFS_W-1:0] step_ext;
  wire [OFS_W-1:0] sum_w;
  wire [OFS_W-1:0] diff_w;
  reg [OFS_W-1:0] offset_d;
  reg wrap_d;

  assign step_ext = {{(OFS_W-STEP_W){1'b0}}, step_size};
  assign sum_w = offset_q + step_ext;
  assign diff_w = offset_q - step_ext;

  // Zero wins over any step; an increment and a decrement in one write
  // cancel, so the offset is left alone.
  always @* begin
    offset_d = offset_q;
    wrap_d = 1'b0;
    if (zero_pulse) begin
      offset_d = {OFS_W{1'b0}};
    end else if (inc_pulse && !dec_pulse) begin
      offset_d = sum_w;
      wrap_d = !offset_q[OFS_W-1] && sum_w[OFS_W-1];
    end else if (dec_pulse && !inc_pulse) begin
      offset_d = diff_w;
      wrap_d = offset_q[OFS_W-1] && !diff_w[OFS_W-1];
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      offset_q <= {OFS_W{1'b0}};
      wrap_q <= 1'b0;
    end else begin
      offset_q <= offset_d;
      wrap_q <= wrap_d;
    end
  end

endmodule

// *** rfo_regs.vh ***
// Purpose: Register indices, field positions and reset values of the
//          reference-clear, phase-offset and validation-override bank.
// Assumes: Byte address on the bus is four times the register index.
// Notes:   Definitions only.
`ifndef RFO_REGS_VH
`define RFO_REGS_VH

`define RFO_IDX_W 14
`define RFO_IDX_CLR_AB 14'h0a08
`define RFO_IDX_CLR_CD 14'h0a09
`define RFO_IDX_PHASE_CTL 14'h0a0a
`define RFO_IDX_FORCE_TMO 14'h0a0b
`define RFO_IDX_MON_OVR 14'h0a0c
`define RFO_IDX_MON_BYP 14'h0a0d
`define RFO_IDX_IRQ_STAT 14'h0a0e
`define RFO_IDX_IRQ_MASK 14'h0a0f
`define RFO_IDX_PHASE_VAL 14'h0a10

// Per-input clear fields: low input at bits 2:0, high input at bits 6:4.
`define RFO_CLR_FAULT 0
`define RFO_CLR_FAULT_CLEARED 1
`define RFO_CLR_VALIDATED 2
`define RFO_CLR_HI_OFS 4
`define RFO_CLR_MASK 8'h77

`define RFO_PH_INC 0
`define RFO_PH_DEC 1
`define RFO_PH_ZERO 2
`define RFO_PH_MASK 8'h07

`define RFO_REF_MASK 4'hf
`define RFO_MON_RST 4'h0

// Interrupt status bits.
`define RFO_EV_STEP 0
`define RFO_EV_WRAP 1
`define RFO_EV_FORCE 2
`define RFO_EV_BUSERR 3
`define RFO_EV_W 4
`define RFO_EV_RST 4'h0
`define RFO_EV_MASK_RST 4'h0

`endif

// *** testbench.sv ***
// Purpose: Self-checking bench for the control bank.
// Assumes: Every transfer is waited out on pready.
// Notes: Step size has its top bit set to catch sign extension.
`timescale 1ns/100ps
module testbench;
  logic clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err_f;
  logic [15:0] paddr = 16'h0, step_size = 16'h8001;
  logic [31:0] pwdata = 32'h0, rd;
  logic [23:0] snap;
  wire pready, pslverr, irq;
  wire [31:0] prdata;
  wire [3:0] ref_fault_clr, ref_fault_cleared_clr, ref_validated_clr;
  wire [3:0] force_timeout, mon_override, mon_bypass;
  wire [23:0] phase_offset;
  int err_count = 0, cmp_count = 0, i;
  typedef struct packed {logic [7:0] ix; logic [7:0] d; logic [23:0] sn;
    logic [7:0] rd; logic [23:0] ph;} rfo_row_t;
  rfo_row_t rows [16] = '{'{8'h08, 8'hff, 24'h333000, 8'h00, 24'h0},
    '{8'h08, 8'h21, 24'h120000, 8'h00, 24'h0}, '{8'h09, 8'hff, 24'hccc000, 8'h00, 24'h0},
    '{8'h09, 8'h14, 24'h804000, 8'h00, 24'h0}, '{8'h0b, 8'hff, 24'h000f00, 8'h00, 24'h0},
    '{8'h0b, 8'h04, 24'h000400, 8'h00, 24'h0}, '{8'h0c, 8'hff, 24'h0000f0, 8'h0f, 24'h0},
    '{8'h0d, 8'ha5, 24'h0000f5, 8'h05, 24'h0}, '{8'h0a, 8'h01, 24'h0000f5, 8'h00, 24'h008001},
    '{8'h0a, 8'h01, 24'h0000f5, 8'h00, 24'h010002}, '{8'h0a, 8'h02, 24'h0000f5, 8'h00, 24'h008001},
    '{8'h0a, 8'h03, 24'h0000f5, 8'h00, 24'h008001}, '{8'h0a, 8'h06, 24'h0000f5, 8'h00, 24'h0},
    '{8'h0a, 8'h02, 24'h0000f5, 8'h00, 24'hff7fff}, '{8'h0a, 8'hf8, 24'h0000f5, 8'h00, 24'hff7fff},
    '{8'h0a, 8'h04, 24'h0000f5, 8'h00, 24'h0}};
  always #25 clk = ~clk;
  rfo_ctrl_bank uut (.clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
    .pslverr, .step_size, .ref_fault_clr, .ref_fault_cleared_clr, .ref_validated_clr,
    .force_timeout, .mon_override, .mon_bypass, .phase_offset, .irq);
  ////////////////////////////////////////
  task complete_run;
    if (err_count == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  // Pulses are snapped at the edge closing the cycle after the write.
  task apb(input logic w, input logic [13:0] ix, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {ix, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err_f = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
    snap = {ref_fault_clr, ref_fault_cleared_clr, ref_validated_clr, force_timeout,
      mon_override, mon_bypass};
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    chk("reset state", 32'h0, {3'h0, irq, mon_override, phase_offset});
    for (i = 0; i < 16; i++) begin
      apb(1'b1, {6'h0a, rows[i].ix}, rows[i].d);
      chk("pulses", {8'h0, rows[i].sn}, snap);
      apb(1'b0, {6'h0a, rows[i].ix}, 8'h0);
      chk("readback", {24'h0, rows[i].rd}, rd);
      chk("no error", 32'h0, {31'h0, err_f});
      chk("offset", {8'h0, rows[i].ph}, phase_offset);
    end
    apb(1'b1, 14'h0a0e, 8'hff);
    apb(1'b1, 14'h0a0f, 8'h04);
    chk("irq idle", 32'h0, {31'h0, irq});
    apb(1'b1, 14'h0a0b, 8'h01);
    @(posedge clk);
    chk("irq raised", 32'h1, {31'h0, irq});
    apb(1'b1, 14'h0a0f, 8'h00);
    @(posedge clk);
    chk("irq masked", 32'h0, {31'h0, irq});
    apb(1'b1, 14'h0a0f, 8'h04);
    apb(1'b1, 14'h0a0e, 8'h04);
    chk("irq cleared", 32'h0, {31'h0, irq});
    apb(1'b0, 14'h0123, 8'h0);
    chk("unmapped", 32'h1, {rd[30:0], err_f});
    apb(1'b0, 14'h0a0e, 8'h0);
    chk("status", 32'h8, rd);
    apb(1'b1, 14'h0a0a, 8'h02);
    apb(1'b0, 14'h0a10, 8'h0);
    chk("offset readback", 32'hffff7fff, rd);
    apb(1'b0, 14'h0a0e, 8'h0);
    chk("step status", 32'h9, rd);
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    chk("mid reset", 32'h0, {mon_override, mon_bypass, phase_offset});
    complete_run;
  end
  initial begin
    repeat (3000) @(posedge clk);
    err_count++;
    complete_run;
  end
endmodule
